// ==== nvb_host.sv ====
/*
  Host controller driving the nonvolatile array's configuration registers and
  its external move port: burst writes fed from a write FIFO, basic or fast
  burst reads, and the block protect sequence. Assumes the device logic runs
  on mclk_in, so its answers are read without synchronisers.
*/
// Behaviour
// R1: Device writes in burst when burst bit set
// R2: Device double-buffers burst write data
// R3: Burst writes go to consecutive rising addresses
// R4: No reads once a burst write started
// R5: Next write within 13/20/28/58 clocks
// R6: Device flags no late burst write
// R7: Burst bit alone gives basic burst read
// R8: Burst plus idle bit gives fast read
// R9: Device prefetches next read byte
// R10: Burst reads go to consecutive rising addresses
// R11: Fast read gap is half basic gap
// R12: No writes once a burst read started
// R13: Read gaps 14/28 22/43 30/58 62/118 clocks
// R14: Device flags no late burst read
// R15: Idle bit reads zero during burst
// R16: Idle returns to one; poll it
// R17: Leave burst before jump or direction change
// R18: Programmed read-only beats block protection
// R19: Protect field selects protected address range
// R20: Protect update only with write latch set
// R21: Latch, idle, load, commit, idle, clear, verify
// R22: Control bit 7 shows module idle
// R23: Operation field codes four protect operations
// R24: Move access stalls until it completes
// R25: Gap counted from completion to next issue
`timescale 1ns/100ps
`default_nettype none
`include "nvb_params.svh"

// Write data FIFO; its ready is registered so it can reach a top output
module nvb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Storage and pointers; DEPTH is taken as a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } nvb_fifo_s;
  nvb_fifo_s f_q, f_d;
  logic push, pop;

  // Next state: push at the tail, pop at the head, count both
  always_comb begin
    f_d = f_q;
    push = in_valid_in && f_q.rdy;
    pop = out_ready_in && (f_q.cnt != '0);
    if (push) begin
      f_d.mem[f_q.wp] = in_data_in;
      f_d.wp = f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = f_q.rp + 1'b1;
    end
    f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Ready is taken from the next count, so the port is a flop with no lag
    f_d.rdy = (f_d.cnt != (AW+1)'(DEPTH));
  end

  // State register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign in_ready_out = f_q.rdy;
  assign out_valid_out = (f_q.cnt != '0);
  assign out_data_out = f_q.mem[f_q.rp];
endmodule

// Top: command sequencer facing the device's configuration and move ports
module nvb_host #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_kind_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [7:0] cmd_len_in,
  input wire logic cmd_fast_in,
  input wire logic [1:0] cmd_div_in,
  input wire logic [1:0] cmd_range_in,
  output logic cmd_ready_out,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic done_out,
  output logic prot_ok_out,
  output logic [7:0] prot_rb_out,
  output logic cfg_wr_out,
  output logic cfg_rd_out,
  output logic cfg_sel_out,
  output logic [7:0] cfg_wdata_out,
  input wire logic [7:0] cfg_rdata_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_done_in
);
  nvb_pkg::nvb_state_s s_q, s_d;
  logic fifo_v, fifo_pop, is_rd;
  logic [7:0] fifo_data;
  logic [7:0] gap_lim; // Longest allowed gap for the current mode

  // Control register byte from its fields
  function automatic logic [7:0] ctrl_byte(input logic [1:0] div, input logic burst,
                                           input logic fast, input logic [1:0] op,
                                           input logic go);
    logic [7:0] b;
    b = 8'h00;
    b[`NVB_IDLE_BIT] = fast;
    b[`NVB_DIV_LSB +: 2] = div;
    b[`NVB_BURST_BIT] = burst;
    b[`NVB_OP_LSB +: 2] = op;
    b[`NVB_GO_BIT] = go;
    return b;
  endfunction

  // Gap limit per direction, read speed and divider setting
  function automatic logic [7:0] gap_limit(input logic rd, input logic fast,
                                           input logic [1:0] div);
    logic [7:0] w, b, f;
    unique case (div)
      2'h0: begin w = `NVB_GAP_W0; b = `NVB_GAP_B0; f = `NVB_GAP_F0; end
      2'h1: begin w = `NVB_GAP_W1; b = `NVB_GAP_B1; f = `NVB_GAP_F1; end
      2'h2: begin w = `NVB_GAP_W2; b = `NVB_GAP_B2; f = `NVB_GAP_F2; end
      2'h3: begin w = `NVB_GAP_W3; b = `NVB_GAP_B3; f = `NVB_GAP_F3; end
    endcase
    return !rd ? w : (fast ? f : b);
  endfunction

  // Write data buffer; full FIFO drops wr_ready_out to the source
  nvb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_nvb_fifo (
    .clk_in(mclk_in),
    .rstn_in(rstn_in),
    .in_valid_in(wr_valid_in),
    .in_data_in(wr_data_in),
    .in_ready_out(wr_ready_out),
    .out_valid_out(fifo_v),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  assign is_rd = (s_q.kind == `NVB_CMD_READ);
  assign gap_lim = gap_limit(is_rd, s_q.fast, s_q.div); // R5 R11 R13

  // Sequencer next state
  always_comb begin
    s_d = s_q;
    s_d.cfg_wr = 1'b0;
    s_d.cfg_rd = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.done = 1'b0;
    fifo_pop = 1'b0;
    unique case (s_q.st)
      nvb_pkg::st_idle: begin
        s_d.ready = 1'b1;
        if (cmd_valid_in && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.kind = cmd_kind_in;
          s_d.addr = cmd_addr_in;
          s_d.left = cmd_len_in;
          s_d.fast = cmd_fast_in;
          s_d.div = cmd_div_in;
          s_d.range = cmd_range_in;
          s_d.step = 3'h0;
          // Codes other than write and read run the protect sequence
          s_d.st = (cmd_kind_in == `NVB_CMD_WRITE || cmd_kind_in == `NVB_CMD_READ) ?
                   nvb_pkg::st_bset : nvb_pkg::st_prot;
        end
      end
      nvb_pkg::st_bset: begin
        // Enter burst; idle bit doubles as fast read select
        s_d.cfg_wr = 1'b1; // R7 R8
        s_d.cfg_sel = `NVB_SEL_CTRL;
        s_d.cfg_wdata = ctrl_byte(s_q.div, 1'b1, is_rd && s_q.fast, `NVB_OP_ENABLE, 1'b0);
        s_d.started = 1'b0;
        s_d.gap = 8'h00;
        s_d.st = nvb_pkg::st_bgap;
      end
      nvb_pkg::st_bgap: begin
        if (s_q.left == 8'h00) begin
          s_d.st = nvb_pkg::st_bexit;
        end else if (is_rd || fifo_v) begin
          // Issue next access; request lands gap+1 clocks after completion
          fifo_pop = !is_rd;
          s_d.mem_req = 1'b1;
          s_d.mem_we = !is_rd; // R4 R12
          s_d.mem_addr = s_q.addr;
          s_d.mem_wdata = fifo_data;
          s_d.st = nvb_pkg::st_bacc;
        end else if (s_q.started && s_q.gap >= gap_lim - 8'h01) begin
          // Data is late: leave burst rather than lose bytes
          s_d.st = nvb_pkg::st_bexit; // R5 R17
        end else begin
          s_d.gap = s_q.gap + 8'h01; // R25
        end
      end
      nvb_pkg::st_bacc: begin
        // Held request until the device finishes the move
        if (mem_done_in) begin // R24
          s_d.mem_req = 1'b0;
          s_d.addr = s_q.addr + 16'h0001; // R3 R10
          s_d.left = s_q.left - 8'h01;
          s_d.started = 1'b1;
          s_d.gap = 8'h00; // R25
          s_d.rd_valid = is_rd;
          if (is_rd) begin
            s_d.rd_data = mem_rdata_in;
          end
          s_d.st = nvb_pkg::st_bgap;
        end
      end
      nvb_pkg::st_bexit: begin
        // Clear burst, then wait for idle before anything else
        s_d.cfg_wr = 1'b1; // R17
        s_d.cfg_sel = `NVB_SEL_CTRL;
        s_d.cfg_wdata = ctrl_byte(s_q.div, 1'b0, 1'b0, `NVB_OP_ENABLE, 1'b0);
        s_d.st = nvb_pkg::st_pollr;
      end
      nvb_pkg::st_pollr: begin
        s_d.cfg_rd = 1'b1;
        s_d.cfg_sel = `NVB_SEL_CTRL;
        s_d.st = nvb_pkg::st_pollc;
      end
      nvb_pkg::st_pollc: begin
        // Device answers within the read strobe cycle, so sample it now
        if (!cfg_rdata_in[`NVB_IDLE_BIT]) begin // R16 R22
          s_d.st = nvb_pkg::st_pollr;
        end else if (s_q.kind == `NVB_CMD_WRITE || s_q.kind == `NVB_CMD_READ) begin
          if (s_q.left != 8'h00) begin
            s_d.st = nvb_pkg::st_bset;
          end else begin
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = nvb_pkg::st_idle;
          end
        end else begin
          s_d.step = s_q.step + 3'h1;
          s_d.st = nvb_pkg::st_prot;
        end
      end
      nvb_pkg::st_prot: begin
        s_d.cfg_wr = 1'b1;
        s_d.cfg_sel = `NVB_SEL_CTRL;
        s_d.st = nvb_pkg::st_pollr;
        unique case (s_q.step)
          3'h0: s_d.cfg_wdata = ctrl_byte(s_q.div, 1'b0, 1'b0, `NVB_OP_ENABLE, 1'b1); // R21
          3'h1: begin
            // Load range with protection on; no poll needed for this write
            s_d.cfg_sel = `NVB_SEL_PROT;
            s_d.cfg_wdata = 8'h00;
            s_d.cfg_wdata[`NVB_APPLY_BIT] = 1'b1;
            s_d.cfg_wdata[`NVB_RANGE_LSB +: 2] = s_q.range; // R21
            s_d.step = 3'h2;
            s_d.st = nvb_pkg::st_prot;
          end
          3'h2: s_d.cfg_wdata = ctrl_byte(s_q.div, 1'b0, 1'b0, `NVB_OP_COMMIT, 1'b1); // R21
          3'h3: s_d.cfg_wdata = ctrl_byte(s_q.div, 1'b0, 1'b0, `NVB_OP_DISABLE, 1'b1); // R21
          default: begin
            // Verify by reading the protect register back
            s_d.cfg_wr = 1'b0;
            s_d.cfg_rd = 1'b1;
            s_d.cfg_sel = `NVB_SEL_PROT;
            s_d.st = nvb_pkg::st_pver;
          end
        endcase
      end
      nvb_pkg::st_pver: begin
        s_d.prot_rb = cfg_rdata_in;
        s_d.prot_ok = cfg_rdata_in[`NVB_APPLY_BIT] &&
                      (cfg_rdata_in[`NVB_RANGE_LSB +: 2] == s_q.range); // R21
        s_d.done = 1'b1;
        s_d.ready = 1'b1;
        s_d.st = nvb_pkg::st_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready_out = s_q.ready;
  assign rd_valid_out = s_q.rd_valid;
  assign rd_data_out = s_q.rd_data;
  assign done_out = s_q.done;
  assign prot_ok_out = s_q.prot_ok;
  assign prot_rb_out = s_q.prot_rb;
  assign cfg_wr_out = s_q.cfg_wr;
  assign cfg_rd_out = s_q.cfg_rd;
  assign cfg_sel_out = s_q.cfg_sel;
  assign cfg_wdata_out = s_q.cfg_wdata;
  assign mem_req_out = s_q.mem_req;
  assign mem_we_out = s_q.mem_we;
  assign mem_addr_out = s_q.mem_addr;
  assign mem_wdata_out = s_q.mem_wdata;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_prot_load;
    cfg_wr_out && cfg_sel_out == `NVB_SEL_PROT;
  endsequence
  sequence s_commit;
    cfg_wr_out && cfg_wdata_out[`NVB_OP_LSB +: 2] == `NVB_OP_COMMIT && cfg_wdata_out[`NVB_GO_BIT];
  endsequence
  sequence s_idle_poll;
    cfg_rd_out && cfg_sel_out == `NVB_SEL_CTRL;
  endsequence

  a_gap_bound: assert property ( // R5 R13
    s_q.st == nvb_pkg::st_bgap && s_q.started |-> s_q.gap < gap_lim)
    else $error("burst gap exceeded its limit");
  a_addr_step: assert property ( // R3 R10
    $rose(mem_req_out) && s_q.started |-> mem_addr_out == $past(mem_addr_out) + 16'h0001)
    else $error("burst address not consecutive");
  a_dir_fixed: assert property ( // R4 R12
    $rose(mem_req_out) && s_q.started |-> mem_we_out == $past(mem_we_out))
    else $error("burst direction changed");
  a_stall_hold: assert property ( // R24
    mem_req_out && !mem_done_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("request dropped before completion");
  a_read_return: assert property ( // R10
    mem_req_out && mem_done_in && !mem_we_out |=> rd_valid_out && rd_data_out == $past(mem_rdata_in))
    else $error("read byte not returned");
  a_fast_select: assert property ( // R8 R11
    cfg_wr_out && !cfg_sel_out && cfg_wdata_out[`NVB_BURST_BIT] |->
      cfg_wdata_out[`NVB_IDLE_BIT] == (is_rd && s_q.fast))
    else $error("fast read select wrong");
  a_exit_poll: assert property ( // R17 R16
    cfg_wr_out && !cfg_sel_out && !cfg_wdata_out[`NVB_BURST_BIT] |=> s_idle_poll)
    else $error("no idle poll after burst exit");
  a_poll_repeat: assert property ( // R16
    s_q.st == nvb_pkg::st_pollc && !cfg_rdata_in[`NVB_IDLE_BIT] |-> ##2 s_idle_poll)
    else $error("busy device not polled again");
  a_prot_commit: assert property ( // R21
    s_prot_load |=> s_commit ##1 s_idle_poll)
    else $error("protect load not committed");
endmodule
`default_nettype wire

// ==== nvb_params.svh ====
/*
  Constants for the nonvolatile burst access host: field positions of the two
  device configuration registers, operation and command codes, gap limits.
  Assumes it is included by bare name from the design file and the bench.
*/
`ifndef NVB_PARAMS_SVH
`define NVB_PARAMS_SVH
// Control register fields
`define NVB_IDLE_BIT 7
`define NVB_DIV_LSB 4
`define NVB_BURST_BIT 3
`define NVB_OP_LSB 1
`define NVB_GO_BIT 0
// Protect register fields
`define NVB_APPLY_BIT 7
`define NVB_RANGE_LSB 2
`define NVB_LATCH_BIT 1
// Register select on the configuration port
`define NVB_SEL_CTRL 1'b0
`define NVB_SEL_PROT 1'b1
// Operation select codes
`define NVB_OP_ENABLE 2'h0
`define NVB_OP_DISABLE 2'h1
`define NVB_OP_REFRESH 2'h2
`define NVB_OP_COMMIT 2'h3
// User command codes
`define NVB_CMD_WRITE 2'h0
`define NVB_CMD_READ 2'h1
`define NVB_CMD_PROT 2'h2
// Last protect step, the verifying read
`define NVB_STEP_VERIFY 3'h4
// Burst write gap limits, clocks, per divider setting
`define NVB_GAP_W0 8'h0d
`define NVB_GAP_W1 8'h14
`define NVB_GAP_W2 8'h1c
`define NVB_GAP_W3 8'h3a
// Basic burst read gap limits
`define NVB_GAP_B0 8'h1c
`define NVB_GAP_B1 8'h2b
`define NVB_GAP_B2 8'h3a
`define NVB_GAP_B3 8'h76
// Fast burst read gap limits
`define NVB_GAP_F0 8'h0e
`define NVB_GAP_F1 8'h16
`define NVB_GAP_F2 8'h1e
`define NVB_GAP_F3 8'h3e
`endif

// ==== nvb_pkg.sv ====
/*
  Types of the nonvolatile burst access host: sequencer states and the
  packed state record. Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package nvb_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    st_idle, st_bset, st_bgap, st_bacc, st_bexit, st_pollr, st_pollc, st_prot, st_pver
  } nvb_state_e;
  // Whole state of the host sequencer
  typedef struct packed {
    nvb_state_e st;
    logic [1:0] kind;
    logic fast;
    logic [1:0] div;
    logic [1:0] range;
    logic [2:0] step;
    logic started;
    logic [15:0] addr;
    logic [7:0] left;
    logic [7:0] gap;
    logic ready;
    logic cfg_wr;
    logic cfg_rd;
    logic cfg_sel;
    logic [7:0] cfg_wdata;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic prot_ok;
    logic [7:0] prot_rb;
  } nvb_state_s;
endpackage
`default_nettype wire

// ==== nvb_dev_model.sv ====
/*
  Behavioural model of the nonvolatile array with its control and protect
  registers, seen from the host side. Assumes one clock shared with the host.
*/
`timescale 1ns/100ps
`default_nettype none
module nvb_dev_model #(
  parameter bit RO_LOCK = 1'b0 // Programmed read-only lock, off unless a test sets it
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] lat_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_sel_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_done_out,
  output logic [7:0] viol_out
);
  logic [7:0] arr [0:8191]; // Array bytes
  logic [7:0] ctrl_q; // Control register as written
  logic [7:0] prot_q; // Protect register mirror
  logic [2:0] nv_prot_q; // Committed apply bit and range
  logic wel_q; // Write latch
  logic [4:0] busy_q; // Cycles left until idle
  logic [3:0] cnt_q; // Access latency left
  logic req_q; // Access in progress
  logic we_q; // Direction of the last burst access
  logic lost_q; // Current access breaks the burst
  logic start_q; // Burst has seen its first access
  logic [15:0] last_q; // Address of the last burst access
  logic [7:0] gap_q; // Clocks since the last completion
  logic [7:0] cfg_float_q; // Value left on the released read bus
  logic idle;
  assign idle = (busy_q == 5'h0) && !ctrl_q[3];
  // Gap limit: 13/20/28/58 write, 14/22/30/62 fast, 28/43/58/118 basic
  function automatic logic [7:0] lim(input logic w, input logic f, input logic [1:0] d);
    case (d)
      2'h0: lim = w ? 8'h0d : (f ? 8'h0e : 8'h1c);
      2'h1: lim = w ? 8'h14 : (f ? 8'h16 : 8'h2b);
      2'h2: lim = w ? 8'h1c : (f ? 8'h1e : 8'h3a);
      default: lim = w ? 8'h3a : (f ? 8'h3e : 8'h76);
    endcase
  endfunction
  // Protected window per committed range
  function automatic logic hit(input logic [2:0] p, input logic [15:0] a);
    case (p[1:0])
      2'h1: hit = p[2] && (a >= 16'h8800) && (a <= 16'h8fff);
      2'h2: hit = p[2] && (a >= 16'h9000);
      2'h3: hit = p[2];
      default: hit = 1'b0;
    endcase
    // A read-only lock set at programming time wins over any range
    if (RO_LOCK) hit = 1'b1;
  endfunction
  // Register port, idle timing and the move port; released buses toggle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {ctrl_q, prot_q, nv_prot_q, wel_q, busy_q, cnt_q} <= '0;
      {req_q, we_q, lost_q, start_q, last_q, gap_q, viol_out} <= '0;
      {cfg_float_q, mem_rdata_out, mem_done_out} <= '0;
    end else begin
      mem_done_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      cfg_float_q <= ~cfg_rdata_out;
      if (busy_q != 5'h0) busy_q <= busy_q - 5'h1;
      gap_q <= mem_done_out ? 8'h0 : (gap_q == 8'hff ? gap_q : gap_q + 8'h1);
      if (cfg_wr_in) begin
        // A host that skips the idle poll is caught here
        if (busy_q != 5'h0) viol_out <= viol_out + 8'h1;
        if (cfg_sel_in) begin
          prot_q <= cfg_wdata_in;
        end else begin
          ctrl_q <= cfg_wdata_in;
          start_q <= 1'b0;
          if (cfg_wdata_in[0] || (ctrl_q[3] && !cfg_wdata_in[3])) begin
            busy_q <= {1'b0, lat_in} + 5'h2;
          end
          if (cfg_wdata_in[0]) begin
            case (cfg_wdata_in[2:1])
              2'h0: wel_q <= 1'b1;
              2'h1: wel_q <= 1'b0;
              2'h2: prot_q <= {nv_prot_q[2], 3'h0, nv_prot_q[1:0], 2'h0};
              default: if (wel_q) nv_prot_q <= {prot_q[7], prot_q[3:2]};
            endcase
          end
        end
      end
      if (mem_req_in && !mem_done_out) begin
        if (!req_q) begin
          // Late, nonconsecutive or turned-round accesses lose data silently
          req_q <= 1'b1;
          cnt_q <= lat_in;
          lost_q <= start_q && ((gap_q > lim(mem_we_in, ctrl_q[7], ctrl_q[5:4]))
                    || (mem_addr_in != last_q + 16'h1) || (mem_we_in != we_q));
          if (busy_q != 5'h0 || (start_q && ((gap_q > lim(mem_we_in, ctrl_q[7], ctrl_q[5:4]))
              || (mem_addr_in != last_q + 16'h1) || (mem_we_in != we_q)))) begin
            viol_out <= viol_out + 8'h1;
          end
        end else if (cnt_q != 4'h0) begin
          cnt_q <= cnt_q - 4'h1;
        end else begin
          mem_done_out <= 1'b1;
          req_q <= 1'b0;
          start_q <= ctrl_q[3];
          last_q <= mem_addr_in;
          we_q <= mem_we_in;
          if (mem_we_in && !lost_q && !hit(nv_prot_q, mem_addr_in)) begin
            arr[mem_addr_in[12:0]] <= mem_wdata_in;
          end
          if (!mem_we_in) begin
            mem_rdata_out <= lost_q ? ~arr[mem_addr_in[12:0]] : arr[mem_addr_in[12:0]];
          end
        end
      end
    end
  end
  // Register reads answer within the strobe cycle; a released bus drifts to the inverse
  always_comb begin
    if (cfg_rd_in) begin
      cfg_rdata_out = cfg_sel_in ? {prot_q[7], 3'h0, prot_q[3:2], wel_q, 1'b0}
                                 : {idle, ctrl_q[6:0]};
    end else begin
      cfg_rdata_out = cfg_float_q;
    end
  end
endmodule
`default_nettype wire

// ==== nvb_host_test.sv ====
/*
  Self-checking bench for the burst access host: random bursts both ways,
  slow write data, a full write buffer and every protect range.
  Assumes the device model is compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "nvb_params.svh"
module nvb_host_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [15:0] cmd_addr = 16'h8000;
  logic [7:0] cmd_len = 8'h0;
  logic cmd_fast = 1'b0;
  logic [1:0] cmd_div = 2'h0;
  logic [1:0] cmd_range = 2'h0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h0;
  logic [3:0] lat = 4'h0;
  logic cmd_ready, wr_ready, rd_valid, done, prot_ok, cfg_wr, cfg_rd, cfg_sel;
  logic mem_req, mem_we, mem_done;
  logic [7:0] rd_data, prot_rb, cfg_wdata, cfg_rdata, mem_wdata, mem_rdata, viol;
  logic [15:0] mem_addr;
  logic [31:0] sm = 32'h91001b93; // Main random state
  logic [31:0] sf = 32'h91001b93; // Feeder random state
  logic [7:0] shadow [0:8191]; // Expected array contents
  logic [7:0] wq[$]; // Every byte ever offered to the write stream
  logic [7:0] rq[$]; // Bytes returned by the current read
  int wi = 0; // Bytes accepted so far
  int wdly = 0; // Feeder stall left
  int wslow = 1; // Feeder stall span
  int n_fail = 0;
  int num_checks = 0;
  nvb_host u_nvb_host (.mclk_in(mclk), .rstn_in(rstn), .cmd_valid_in(cmd_valid),
    .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len),
    .cmd_fast_in(cmd_fast), .cmd_div_in(cmd_div), .cmd_range_in(cmd_range),
    .cmd_ready_out(cmd_ready), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
    .wr_ready_out(wr_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .done_out(done), .prot_ok_out(prot_ok), .prot_rb_out(prot_rb), .cfg_wr_out(cfg_wr),
    .cfg_rd_out(cfg_rd), .cfg_sel_out(cfg_sel), .cfg_wdata_out(cfg_wdata),
    .cfg_rdata_in(cfg_rdata), .mem_req_out(mem_req), .mem_we_out(mem_we),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
    .mem_done_in(mem_done));
  nvb_dev_model u_nvb_dev_model (.clk_in(mclk), .rstn_in(rstn), .lat_in(lat),
    .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd), .cfg_sel_in(cfg_sel), .cfg_wdata_in(cfg_wdata),
    .cfg_rdata_out(cfg_rdata), .mem_req_in(mem_req), .mem_we_in(mem_we),
    .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata), .mem_rdata_out(mem_rdata),
    .mem_done_out(mem_done), .viol_out(viol));
  // 10 MHz clock
  always #50 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Write stream feeder; holds a byte until taken, stalls at random between bytes
  always @(posedge mclk) begin
    if (wr_valid && wr_ready) begin
      wi++;
      sf = xs(sf);
      wdly = sf % wslow;
    end
    if (!(wr_valid && !wr_ready)) begin
      if (wdly != 0) wdly--;
      wr_valid <= (wdly == 0) && (wi < wq.size());
      if (wi < wq.size()) wr_data <= wq[wi];
    end
  end
  // Read collector; the data port has no back-pressure
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
  end
  // One command, bounded wait for its done pulse
  task automatic run(input logic [1:0] k, input logic [15:0] a, input logic [7:0] n,
                     input logic f, input logic [1:0] d, input logic [1:0] r);
    int t;
    t = 0;
    @(posedge mclk);
    {cmd_valid, cmd_kind, cmd_addr, cmd_len, cmd_fast, cmd_div, cmd_range} <= {1'b1, k, a, n, f, d, r};
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      t++;
    end while (done !== 1'b1 && t < 20000);
    check("done", {15'h0, t < 20000}, 16'h1);
  endtask
  // Write n random bytes from a, then read them back; keep means protected
  task automatic burst(input logic [15:0] a, input logic [7:0] n, input logic keep,
                       input int pre, input int slow);
    int w0;
    @(negedge mclk);
    w0 = wi;
    wslow = slow;
    sm = xs(sm);
    lat = sm[3:0];
    for (int k = 0; k < n; k++) begin
      sm = xs(sm);
      wq.push_back(sm[7:0]);
      if (!keep) shadow[a[12:0] + 13'(k)] = sm[7:0];
    end
    repeat (pre) @(posedge mclk);
    if (pre != 0) check("fifo fill", 16'(wi - w0), 16'h10);
    if (pre != 0) check("fifo full", {15'h0, wr_ready}, 16'h0);
    run(`NVB_CMD_WRITE, a, n, 1'b0, sm[9:8], 2'h0);
    rq.delete();
    run(`NVB_CMD_READ, a, n, sm[10], sm[12:11], 2'h0);
    check("read count", 16'(rq.size()), {8'h0, n});
    foreach (rq[k]) check("read data", {8'h0, rq[k]}, {8'h0, shadow[a[12:0] + 13'(k)]});
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    check("ready after reset", {15'h0, cmd_ready}, 16'h1);
    run(`NVB_CMD_WRITE, 16'h8000, 8'h0, 1'b0, 2'h1, 2'h0);
    for (int i = 0; i < 8; i++) begin
      sm = xs(sm);
      burst(16'h8000 | (sm[15:0] & 16'h1f00), 8'h1 + 8'(sm[20:16] % 24), 1'b0, 0,
            (i % 3 == 1) ? 40 : 1);
    end
    burst(16'h8400, 8'h14, 1'b0, 40, 1);
    for (int r = 0; r < 4; r++) begin
      run((r == 3) ? 2'h3 : `NVB_CMD_PROT, 16'h8000, 8'h0, 1'b0, 2'(r), 2'(r));
      check("readback", {8'h0, prot_rb}, {8'h0, 1'b1, 3'h0, 2'(r), 2'h0});
      check("protect ok", {15'h0, prot_ok}, 16'h1);
      check("committed", {13'h0, u_nvb_dev_model.nv_prot_q}, {13'h0, 1'b1, 2'(r)});
    end
    burst(16'h8400, 8'h4, 1'b1, 0, 1);
    check("device rule breaks", {8'h0, viol}, 16'h0);
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
